//--- pkg/scpm_pkg.sv
// Shared constants and carriers for the system clock and power mode block.
// Assumes a single mclk domain at 100 MHz with synchronous active-low reset.
`default_nettype none
package scpm_pkg;
  // APB register byte offsets
  localparam logic [7:0] CLK_MODE_OFS = 8'h00;
  localparam logic [7:0] IDLE_CTRL_OFS = 8'h04;
  localparam logic [7:0] HALT_CMD_OFS = 8'h08;
  localparam logic [7:0] STATUS_OFS = 8'h0c;
  // Clock mode register fields
  localparam int SEL_HL_BIT = 0;
  localparam int IDLE_EN_BIT = 1;
  localparam int FAST_RDY_BIT = 2;
  localparam int SLOW_RDY_BIT = 3;
  localparam int DIV_LSB = 5;
  // Idle control register fields
  localparam int SYSKEEP_BIT = 7;
  localparam int WDT_EN_BIT = 0;
  // Reset values
  localparam logic [2:0] DIV_SEL_RST = 3'h0;
  localparam logic SEL_HL_RST = 1'b1;
  localparam logic IDLE_EN_RST = 1'b1;
  localparam logic SYSKEEP_RST = 1'b0;
  localparam logic WDT_EN_RST = 1'b1;
  // Oscillator figures and derived counts at mclk
  localparam int MCLK_HZ = 100_000_000;
  localparam int FAST_OSC_HZ_LO = 4_000_000;
  localparam int FAST_OSC_HZ_HI = 8_000_000;
  localparam int SLOW_OSC_HZ = 32_000;
  localparam int FAST_HALF_LO = MCLK_HZ / (2 * FAST_OSC_HZ_LO);
  localparam int FAST_HALF_HI = MCLK_HZ / (2 * FAST_OSC_HZ_HI);
  localparam int SLOW_HALF = MCLK_HZ / (2 * SLOW_OSC_HZ);
  // Oscillator settle time in own-clock cycles
  localparam int FAST_SETTLE_CYC = 16;
  localparam int SLOW_SETTLE_CYC = 2;
  // Operating modes
  typedef enum logic [2:0] {
    MODE_NORMAL, MODE_SLOW, MODE_CLOCK_STOPPED_IDLE_MODE, MODE_CLOCK_RUNNING_IDLE_MODE, MODE_DEEP_SLEEP_MODE, MODE_WATCHDOG_SLEEP_MODE
  } scpm_mode_t;
  // Clock outputs group
  typedef struct packed {
    logic sys_clk;
    logic cpu_clk;
    logic wdt_clk;
    logic timebase_clock;
  } scpm_clocks_t;
endpackage : scpm_pkg
`default_nettype wire

//--- src/scpm_rc_osc.sv
// Behavioural RC oscillator: toggles after a half-period count of mclk.
// Assumes enable comes from mclk logic; ready rises after a settle count.
`default_nettype none
module scpm_rc_osc #(
  parameter int HALF_W = 12,
  parameter int SETTLE = 2
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Control
  input wire logic enable,
  input wire logic [HALF_W-1:0] half_period,
  // Outputs
  output logic osc_out,
  output logic osc_rise,
  output logic ready
);
  logic [HALF_W-1:0] cnt_reg;
  logic [7:0] settle_reg;

  // Half-period counter and output toggle
  always_ff @(posedge mclk) begin
    if (!nrst || !enable) begin
      cnt_reg <= '0;
      osc_out <= 1'b0;
      osc_rise <= 1'b0;
    end else if (cnt_reg >= half_period - HALF_W'(1)) begin
      cnt_reg <= '0;
      osc_out <= ~osc_out;
      osc_rise <= ~osc_out;
    end else begin
      cnt_reg <= cnt_reg + HALF_W'(1);
      osc_rise <= 1'b0;
    end
  end

  // Stability count in oscillator cycles
  always_ff @(posedge mclk) begin
    if (!nrst || !enable) begin
      settle_reg <= '0;
      ready <= 1'b0;
    end else if (osc_rise && !ready) begin
      settle_reg <= settle_reg + 8'h01;
      ready <= (settle_reg >= 8'(SETTLE - 1));
    end
  end
endmodule : scpm_rc_osc
`default_nettype wire

//--- src/scpm_glitch_mux.sv
// Glitch-free clock source selector, enable-based, sampled at mclk.
// Assumes all source clocks are mclk-sampled levels with rise pulses.
`default_nettype none
module scpm_glitch_mux (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Sources
  input wire logic [7:0] src_lvl,
  input wire logic [2:0] want_sel,
  input wire logic run,
  // Output
  output logic clk_out,
  output logic [2:0] cur_sel
);
  // Switch only while the mux output and the chosen source are low
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      cur_sel <= 3'h0;
      clk_out <= 1'b0;
    end else begin
      if (want_sel != cur_sel && !clk_out && !src_lvl[want_sel]) begin
        cur_sel <= want_sel;
      end
      clk_out <= run && src_lvl[cur_sel] && (want_sel == cur_sel || clk_out);
    end
  end
endmodule : scpm_glitch_mux
`default_nettype wire

//--- src/scpm_clock_ctrl.sv
// System clock generation and operating mode control with APB registers.
// Assumes an APB master on mclk and a CPU that signals halt and wake.
`default_nettype none
module scpm_clock_ctrl #(
  parameter bit FAST_8MHZ = 1'b1
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // CPU halt and wake
  input wire logic halt_req,
  input wire logic wake_req,
  // Clocks and state out
  output scpm_pkg::scpm_clocks_t clocks,
  output scpm_pkg::scpm_mode_t mode,
  output logic fast_osc_ready,
  output logic slow_osc_ready
);
  // Register state
  logic [2:0] clock_divider_select_reg;
  logic high_low_clock_select_reg;
  logic idle_enable_reg;
  logic idle_sysclk_keep_reg;
  logic wdt_enable_reg;
  scpm_pkg::scpm_mode_t mode_next;
  // Synchronised pins
  logic halt_s1, halt_s2, halt_s3, wake_s1, wake_s2;
  // Oscillators
  logic fast_en, slow_en, fast_lvl, fast_rise, fast_rdy, slow_lvl, slow_rise, slow_rdy;
  logic [11:0] fast_half;
  logic [5:0] div_cnt_reg;
  logic [7:0] src_lvl;
  logic [2:0] want_sel, cur_sel;
  logic sys_run, sys_clk;
  logic apb_wr, apb_rd, addr_ok;

  // Source index: 0 slow, 1 fast, 2..7 fast/64..fast/2
  function automatic logic [2:0] src_index(input logic hl, input logic [2:0] cks);
    if (hl) begin
      return 3'h1;
    end else if (cks <= 3'h1) begin
      return 3'h0;
    end else begin
      return cks;
    end
  endfunction : src_index

  // Two-stage synchronisers for CPU halt and wake
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      halt_s1 <= 1'b0;
      halt_s2 <= 1'b0;
      halt_s3 <= 1'b0;
      wake_s1 <= 1'b0;
      wake_s2 <= 1'b0;
    end else begin
      halt_s1 <= halt_req;
      halt_s2 <= halt_s1;
      halt_s3 <= halt_s2;
      wake_s1 <= wake_req;
      wake_s2 <= wake_s1;
    end
  end

  // APB decode; zero wait states
  assign apb_wr = psel && penable && pwrite;
  assign apb_rd = psel && !penable && !pwrite;
  assign addr_ok = paddr == scpm_pkg::CLK_MODE_OFS || paddr == scpm_pkg::IDLE_CTRL_OFS ||
                   paddr == scpm_pkg::HALT_CMD_OFS || paddr == scpm_pkg::STATUS_OFS;

  // Control register writes
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      clock_divider_select_reg <= scpm_pkg::DIV_SEL_RST;
      high_low_clock_select_reg <= scpm_pkg::SEL_HL_RST;
      idle_enable_reg <= scpm_pkg::IDLE_EN_RST;
      idle_sysclk_keep_reg <= scpm_pkg::SYSKEEP_RST;
      wdt_enable_reg <= scpm_pkg::WDT_EN_RST;
    end else if (apb_wr && paddr == scpm_pkg::CLK_MODE_OFS) begin
      clock_divider_select_reg <= pwdata[scpm_pkg::DIV_LSB +: 3];
      high_low_clock_select_reg <= pwdata[scpm_pkg::SEL_HL_BIT];
      idle_enable_reg <= pwdata[scpm_pkg::IDLE_EN_BIT];
    end else if (apb_wr && paddr == scpm_pkg::IDLE_CTRL_OFS) begin
      idle_sysclk_keep_reg <= pwdata[scpm_pkg::SYSKEEP_BIT];
      wdt_enable_reg <= pwdata[scpm_pkg::WDT_EN_BIT];
    end
  end

  // Read data and response, registered in setup phase
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
      if (apb_rd) begin
        case (paddr)
          scpm_pkg::CLK_MODE_OFS: begin
            prdata <= {24'h0, clock_divider_select_reg, 1'b0, slow_osc_ready, fast_osc_ready,
                       idle_enable_reg, high_low_clock_select_reg};
          end
          scpm_pkg::IDLE_CTRL_OFS: begin
            prdata <= {24'h0, idle_sysclk_keep_reg, 6'h0, wdt_enable_reg};
          end
          scpm_pkg::STATUS_OFS: begin
            prdata <= {26'h0, cur_sel, mode};
          end
          default: begin
            prdata <= 32'h0;
          end
        endcase
      end
    end
  end

  // Next mode: halt command by pin edge or register write
  always_comb begin
    mode_next = mode;
    case (mode)
      scpm_pkg::MODE_NORMAL, scpm_pkg::MODE_SLOW: begin
        if ((halt_s2 && !halt_s3) || (apb_wr && paddr == scpm_pkg::HALT_CMD_OFS)) begin
          if (!idle_enable_reg) begin
            mode_next = wdt_enable_reg ? scpm_pkg::MODE_WATCHDOG_SLEEP_MODE : scpm_pkg::MODE_DEEP_SLEEP_MODE;
          end else if (idle_sysclk_keep_reg) begin
            mode_next = scpm_pkg::MODE_CLOCK_RUNNING_IDLE_MODE;
          end else begin
            mode_next = scpm_pkg::MODE_CLOCK_STOPPED_IDLE_MODE;
          end
        end else if (src_index(high_low_clock_select_reg, clock_divider_select_reg) == 3'h0) begin
          mode_next = scpm_pkg::MODE_SLOW;
        end else begin
          mode_next = scpm_pkg::MODE_NORMAL;
        end
      end
      scpm_pkg::MODE_CLOCK_STOPPED_IDLE_MODE, scpm_pkg::MODE_CLOCK_RUNNING_IDLE_MODE, scpm_pkg::MODE_DEEP_SLEEP_MODE, scpm_pkg::MODE_WATCHDOG_SLEEP_MODE: begin
        if (wake_s2) begin
          mode_next = scpm_pkg::MODE_NORMAL;
        end
      end
      default: begin
        mode_next = scpm_pkg::MODE_NORMAL;
      end
    endcase
  end

  // Mode register
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      mode <= scpm_pkg::MODE_NORMAL;
    end else begin
      mode <= mode_next;
    end
  end

  // Oscillator enables
  assign want_sel = src_index(high_low_clock_select_reg, clock_divider_select_reg);
  assign fast_en = want_sel != 3'h0 && cur_sel != 3'h0 ? (mode == scpm_pkg::MODE_NORMAL ||
                   mode == scpm_pkg::MODE_CLOCK_RUNNING_IDLE_MODE) : (want_sel != 3'h0 && mode == scpm_pkg::MODE_SLOW);
  assign slow_en = !(mode == scpm_pkg::MODE_DEEP_SLEEP_MODE ||
                     (mode == scpm_pkg::MODE_WATCHDOG_SLEEP_MODE && !wdt_enable_reg));
  assign fast_half = FAST_8MHZ ? 12'(scpm_pkg::FAST_HALF_HI) : 12'(scpm_pkg::FAST_HALF_LO);

  // Fast RC oscillator
  scpm_rc_osc #(.HALF_W(12), .SETTLE(scpm_pkg::FAST_SETTLE_CYC)) u_fast_osc (
    .mclk(mclk),
    .nrst(nrst),
    .enable(fast_en),
    .half_period(fast_half),
    .osc_out(fast_lvl),
    .osc_rise(fast_rise),
    .ready(fast_rdy)
  );

  // Slow RC oscillator
  scpm_rc_osc #(.HALF_W(12), .SETTLE(scpm_pkg::SLOW_SETTLE_CYC)) u_slow_osc (
    .mclk(mclk),
    .nrst(nrst),
    .enable(slow_en),
    .half_period(12'(scpm_pkg::SLOW_HALF)),
    .osc_out(slow_lvl),
    .osc_rise(slow_rise),
    .ready(slow_rdy)
  );

  // Binary counter divider of the fast clock, stepped on each fast rise at mclk
  always_ff @(posedge mclk) begin
    if (!nrst || !fast_en) begin
      div_cnt_reg <= 6'h0;
    end else if (fast_rise) begin
      div_cnt_reg <= div_cnt_reg + 6'h01;
    end
  end

  // Source levels: fast/64 at index 2 down to fast/2 at index 7
  assign src_lvl = {div_cnt_reg[0], div_cnt_reg[1], div_cnt_reg[2], div_cnt_reg[3],
                    div_cnt_reg[4], div_cnt_reg[5], fast_lvl, slow_lvl};
  assign sys_run = mode != scpm_pkg::MODE_CLOCK_STOPPED_IDLE_MODE && mode != scpm_pkg::MODE_DEEP_SLEEP_MODE &&
                   mode != scpm_pkg::MODE_WATCHDOG_SLEEP_MODE;

  // Glitch-free system clock selection
  scpm_glitch_mux u_sys_mux (
    .mclk(mclk),
    .nrst(nrst),
    .src_lvl(src_lvl),
    .want_sel(want_sel),
    .run(sys_run),
    .clk_out(sys_clk),
    .cur_sel(cur_sel)
  );

  // Registered clock and flag outputs
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      clocks <= '0;
      fast_osc_ready <= 1'b0;
      slow_osc_ready <= 1'b0;
    end else begin
      clocks.sys_clk <= sys_clk;
      clocks.cpu_clk <= sys_clk && (mode == scpm_pkg::MODE_NORMAL || mode == scpm_pkg::MODE_SLOW);
      clocks.wdt_clk <= slow_lvl && wdt_enable_reg && mode != scpm_pkg::MODE_DEEP_SLEEP_MODE;
      clocks.timebase_clock <= slow_lvl && mode != scpm_pkg::MODE_DEEP_SLEEP_MODE &&
                               mode != scpm_pkg::MODE_WATCHDOG_SLEEP_MODE;
      fast_osc_ready <= fast_rdy;
      slow_osc_ready <= slow_rdy;
    end
  end
endmodule : scpm_clock_ctrl
`default_nettype wire

//--- verification/scpm_clock_ctrl_sva.sv
// Checker for the clock and power mode block: APB answer and mode entry.
// Assumes it is bound to scpm_clock_ctrl and sees only its ports.
`default_nettype none
module scpm_clock_ctrl_sva #(
  parameter bit FAST_8MHZ = 1'b1
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // CPU and clock outputs
  input wire logic halt_req,
  input wire logic wake_req,
  input wire scpm_pkg::scpm_clocks_t clocks,
  input wire scpm_pkg::scpm_mode_t mode,
  input wire logic fast_osc_ready,
  input wire logic slow_osc_ready
);
  logic wr_acc;
  logic halt_cmd;
  logic idle_en_reg;
  logic keep_reg;
  logic wdt_reg;
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  // Completed write and accepted halt command
  assign wr_acc = psel && penable && pready && pwrite;
  assign halt_cmd = wr_acc && paddr == scpm_pkg::HALT_CMD_OFS && !wake_req
    && mode inside {scpm_pkg::MODE_NORMAL, scpm_pkg::MODE_SLOW};
  // Shadow of the bits that steer a halt
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      idle_en_reg <= scpm_pkg::IDLE_EN_RST;
      keep_reg <= scpm_pkg::SYSKEEP_RST;
      wdt_reg <= scpm_pkg::WDT_EN_RST;
    end else if (wr_acc && paddr == scpm_pkg::CLK_MODE_OFS) begin
      idle_en_reg <= pwdata[scpm_pkg::IDLE_EN_BIT];
    end else if (wr_acc && paddr == scpm_pkg::IDLE_CTRL_OFS) begin
      keep_reg <= pwdata[scpm_pkg::SYSKEEP_BIT];
      wdt_reg <= pwdata[scpm_pkg::WDT_EN_BIT];
    end
  end
  a_apb_zero_wait: assert property (psel && !penable |=> pready) else $error("no answer after setup");
  a_err_unmapped: assert property (pready && !pwrite && paddr > scpm_pkg::STATUS_OFS |-> pslverr && prdata == 32'h0)
    else $error("unmapped read not refused");
  a_halt_deep_sleep: assert property (halt_cmd && !idle_en_reg && !wdt_reg |-> ##[1:2] mode == scpm_pkg::MODE_DEEP_SLEEP_MODE)
    else $error("deep sleep not entered");
  a_halt_wdog_sleep: assert property (halt_cmd && !idle_en_reg && wdt_reg |-> ##[1:2] mode == scpm_pkg::MODE_WATCHDOG_SLEEP_MODE)
    else $error("watchdog sleep not entered");
  a_halt_idle_stop: assert property (halt_cmd && idle_en_reg && !keep_reg |-> ##[1:2] mode == scpm_pkg::MODE_CLOCK_STOPPED_IDLE_MODE)
    else $error("stopped idle not entered");
  a_halt_idle_run: assert property (halt_cmd && idle_en_reg && keep_reg |-> ##[1:2] mode == scpm_pkg::MODE_CLOCK_RUNNING_IDLE_MODE)
    else $error("running idle not entered");
  a_deep_sleep_stop: assert property ((mode == scpm_pkg::MODE_DEEP_SLEEP_MODE)[*2] ##0 clocks == 4'h0
    |=> mode != scpm_pkg::MODE_DEEP_SLEEP_MODE || clocks == 4'h0) else $error("clock runs in deep sleep");
  a_idle_stop_clk: assert property ((mode == scpm_pkg::MODE_CLOCK_STOPPED_IDLE_MODE)[*2] ##0 !clocks.sys_clk && !clocks.cpu_clk
    |=> mode != scpm_pkg::MODE_CLOCK_STOPPED_IDLE_MODE || !(clocks.sys_clk || clocks.cpu_clk)) else $error("clock runs in idle");
  a_slow_fast_off: assert property ((mode == scpm_pkg::MODE_SLOW)[*8] |-> !fast_osc_ready)
    else $error("fast oscillator on in slow mode");
endmodule : scpm_clock_ctrl_sva
bind scpm_clock_ctrl scpm_clock_ctrl_sva #(.FAST_8MHZ(FAST_8MHZ)) i_scpm_clock_ctrl_sva (.mclk(mclk), .nrst(nrst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .halt_req(halt_req), .wake_req(wake_req), .clocks(clocks),
  .mode(mode), .fast_osc_ready(fast_osc_ready), .slow_osc_ready(slow_osc_ready));
`default_nettype wire

//--- verification/scpm_clock_ctrl_bench.sv
// Testbench for the clock and power mode block: registers, sources, halts.
// Assumes the bound checker and a 100 MHz mclk made here.
`default_nettype none
module scpm_clock_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic wake_req = 1'b0;
  logic halt_req = 1'b0;
  scpm_pkg::scpm_clocks_t clocks;
  scpm_pkg::scpm_mode_t mode;
  logic fast_osc_ready;
  logic slow_osc_ready;
  logic [31:0] rd_word;
  logic rd_err;
  int err_count = 0;
  int samples_checked = 0;
  // Device under test
  scpm_clock_ctrl #(.FAST_8MHZ(1'b1)) i_scpm_clock_ctrl (.mclk(mclk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .halt_req(halt_req), .wake_req(wake_req), .clocks(clocks), .mode(mode),
    .fast_osc_ready(fast_osc_ready), .slow_osc_ready(slow_osc_ready));
  // Clock
  always #5 mclk = ~mclk;
  task automatic close_out;
    if (err_count == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : close_out
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : check_word
  task automatic check_mode(input scpm_pkg::scpm_mode_t got, input scpm_pkg::scpm_mode_t exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : check_mode
  // One APB transfer, held until pready
  task automatic apb_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rd_word = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb_xfer
  // Period of one clock output in mclk cycles
  task automatic measure(input int idx, input int exp);
    time t0;
    @(posedge clocks[idx]);
    t0 = $time;
    @(posedge clocks[idx]);
    check_word(32'(($time - t0) / 10), 32'(exp));
  endtask : measure
  // Poll status until source and mode match
  task automatic wait_status(input logic [5:0] exp);
    int n;
    n = 0;
    do begin
      apb_xfer(1'b0, scpm_pkg::STATUS_OFS, 32'h0);
      n++;
    end while (rd_word[5:0] !== exp && n < 3000);
    check_word(rd_word, {26'h0, exp});
  endtask : wait_status
  task automatic test_reset;
    check_word({31'h0, fast_osc_ready}, 32'h0);
    repeat (8000) @(posedge mclk);
    apb_xfer(1'b0, scpm_pkg::CLK_MODE_OFS, 32'h0);
    check_word(rd_word, 32'h0f);
    check_word({31'h0, slow_osc_ready}, 32'h1);
    apb_xfer(1'b0, scpm_pkg::IDLE_CTRL_OFS, 32'h0);
    check_word(rd_word, 32'h01);
    measure(1, 2 * scpm_pkg::SLOW_HALF);
    measure(0, 2 * scpm_pkg::SLOW_HALF);
  endtask : test_reset
  task automatic test_unmapped;
    apb_xfer(1'b1, 8'h10, 32'hffffffff);
    apb_xfer(1'b0, 8'h10, 32'h0);
    check_word({rd_word[30:0], rd_err}, 32'h1);
  endtask : test_unmapped
  task automatic test_sources;
    for (int c = 0; c < 8; c++) begin
      apb_xfer(1'b1, scpm_pkg::CLK_MODE_OFS, 32'(c << 5) | 32'h2);
      if (c < 2) begin
        wait_status({3'h0, scpm_pkg::MODE_SLOW});
        measure(3, 2 * scpm_pkg::SLOW_HALF);
      end else begin
        wait_status({3'(c), scpm_pkg::MODE_NORMAL});
        measure(3, (2 * scpm_pkg::FAST_HALF_HI) << (8 - c));
      end
    end
    apb_xfer(1'b1, scpm_pkg::CLK_MODE_OFS, 32'h3);
    wait_status({3'h1, scpm_pkg::MODE_NORMAL});
    measure(3, 2 * scpm_pkg::FAST_HALF_HI);
    measure(2, 2 * scpm_pkg::FAST_HALF_HI);
  endtask : test_sources
  // Halt by the CPU pin, then wake
  task automatic test_halt_pin;
    halt_req <= 1'b1;
    repeat (5) @(posedge mclk);
    check_mode(mode, scpm_pkg::MODE_CLOCK_RUNNING_IDLE_MODE);
    halt_req <= 1'b0;
    wake_req <= 1'b1;
    repeat (3) @(posedge mclk);
    wake_req <= 1'b0;
    repeat (8) @(posedge mclk);
    check_mode(mode, scpm_pkg::MODE_NORMAL);
  endtask : test_halt_pin
  task automatic test_halt;
    logic [2:0] cfg [4] = '{3'b000, 3'b001, 3'b101, 3'b111};
    scpm_pkg::scpm_mode_t em [4] = '{scpm_pkg::MODE_DEEP_SLEEP_MODE, scpm_pkg::MODE_WATCHDOG_SLEEP_MODE, scpm_pkg::MODE_CLOCK_STOPPED_IDLE_MODE,
      scpm_pkg::MODE_CLOCK_RUNNING_IDLE_MODE};
    for (int i = 0; i < 4; i++) begin
      apb_xfer(1'b1, scpm_pkg::IDLE_CTRL_OFS, {24'h0, cfg[i][1], 6'h0, cfg[i][0]});
      apb_xfer(1'b1, scpm_pkg::CLK_MODE_OFS, {30'h0, cfg[i][2], 1'b1});
      apb_xfer(1'b1, scpm_pkg::HALT_CMD_OFS, 32'h0);
      repeat (3) @(posedge mclk);
      check_mode(mode, em[i]);
      check_word({31'h0, clocks.cpu_clk}, 32'h0);
      if (i == 0) check_word({31'h0, slow_osc_ready}, 32'h0);
      if (i == 1) measure(1, 2 * scpm_pkg::SLOW_HALF);
      if (i == 3) measure(3, 2 * scpm_pkg::FAST_HALF_HI);
      wake_req <= 1'b1;
      repeat (3) @(posedge mclk);
      wake_req <= 1'b0;
      repeat (8) @(posedge mclk);
      check_mode(mode, scpm_pkg::MODE_NORMAL);
    end
  endtask : test_halt
  // Main sequence
  initial begin
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    test_reset();
    test_unmapped();
    test_sources();
    test_halt();
    test_halt_pin();
    close_out();
  end
  // Watchdog against a hang
  initial begin
    #1_000_000;
    err_count++;
    close_out();
  end
endmodule : scpm_clock_ctrl_bench
`default_nettype wire
